/* File: verilog/srctl_regs.svh */
/*
  Offsets, field positions, reset values and timing counts of the switch
  reset and strap control registers.
  Assumes inclusion by bare name from the design module.
*/
`ifndef SRCTL_REGS_SVH
`define SRCTL_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SRCTL_OFS_BUDGET_BASE   12'h300
`define SRCTL_OFS_BUDGET_LAST   12'h31c
`define SRCTL_OFS_BUDGET_SEL    12'h284
`define SRCTL_OFS_BUDGET_READ   12'h288
`define SRCTL_OFS_STRAP_STATUS  12'h400
`define SRCTL_OFS_RESET_CONTROL 12'h404

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SRCTL_STS_MODE_LSB      0
`define SRCTL_STS_STRAP_LSB     5
`define SRCTL_CTL_FUND_BIT      0
`define SRCTL_CTL_HOT_BIT       1
`define SRCTL_CTL_HOLD_BIT      2
`define SRCTL_CTL_UNLOCK_BIT    3
`define SRCTL_CTL_BUDGET_BIT    4
`define SRCTL_CTL_LDDIS_BIT     5

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define SRCTL_BUDGET_WORD_RST   32'h00000000
`define SRCTL_SEL_RST           8'h00
`define SRCTL_DELAY_NS          1000000
`define SRCTL_CLK_NS            20
`define SRCTL_DELAY_CYCLES      ((`SRCTL_DELAY_NS + `SRCTL_CLK_NS - 1) / `SRCTL_CLK_NS)

`endif

/* File: verilog/srctl_pkg.sv */
/*
  Types shared by the switch reset and strap control registers.
  Assumes srctl_regs.svh holds the register offsets, field positions, reset values and timing constants.
*/
package srctl_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } srctl_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } srctl_rsp_t;

  typedef struct packed {
    logic [2:0] mode;
    logic       clkDown;
    logic       clkUp;
    logic       smbSlow;
    logic       refClkMode;
    logic       resetHold;
  } srctl_strap_t;

  typedef enum logic [1:0] {
    SRCTL_IDLE,
    SRCTL_WAIT_FUND,
    SRCTL_WAIT_HOT
  } srctl_state_t;

endpackage : srctl_pkg

/* File: verilog/srctl_top.sv */
/*
  Switch-wide status and control registers: eight power budget data
  words, the strap status word and the reset control word, with delayed
  self-initiated fundamental and hot reset.
  Assumes requests come from a configuration or SMBus front end that
  presents one request per cycle and takes the completion on rspOut.
  fundRstIn is the switch fundamental reset, hotRstIn an external hot
  reset; both are synchronous to clk_sys like sys_rst.
*/
`timescale 1ns/1ps
`include "srctl_regs.svh"

module srctl_top #(
  parameter int unsigned DELAY_CYCLES = `SRCTL_DELAY_CYCLES,
  parameter int unsigned WORDS        = 8
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 fundRstIn,
  input  wire logic                 hotRstIn,
  input  wire logic                 linkDownIn,
  input  wire logic                 eepromInitIn,
  input  wire srctl_pkg::srctl_strap_t strapIn,
  input  wire srctl_pkg::srctl_req_t   reqIn,
  output      srctl_pkg::srctl_rsp_t   rspOut,
  output      logic                 fundRstOut,
  output      logic                 hotRstOut,
  output      logic                 linkRetrainOut,
  output      logic                 coreHoldOut,
  output      logic                 lockableWriteEnOut
);
  import srctl_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [31:0]  budgetWord_r [WORDS];
  logic [7:0]   budgetSel_r;
  srctl_strap_t strap_r;
  logic         resetHold_r;
  logic         lockUnlock_r;
  logic         budgetUnlock_r;
  logic         linkDownDis_r;
  logic         inReset_r;
  srctl_state_t state_r;
  srctl_state_t state_nxt;
  logic [31:0]  delay_r;
  logic [31:0]  delay_nxt;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic logic isBudget(input logic [11:0] a);
    isBudget = (a >= `SRCTL_OFS_BUDGET_BASE) && (a <= `SRCTL_OFS_BUDGET_LAST)
               && (a[1:0] == 2'h0);
  endfunction : isBudget

  wire         wrEn       = reqIn.valid & reqIn.write;
  wire         rdEn       = reqIn.valid & ~reqIn.write;
  wire         hitBudget  = isBudget(reqIn.addr);
  wire [2:0]   budgetIdx  = reqIn.addr[4:2];
  wire         hitSel     = reqIn.addr == `SRCTL_OFS_BUDGET_SEL;
  wire         hitRead    = reqIn.addr == `SRCTL_OFS_BUDGET_READ;
  wire         hitStatus  = reqIn.addr == `SRCTL_OFS_STRAP_STATUS;
  wire         hitControl = reqIn.addr == `SRCTL_OFS_RESET_CONTROL;
  wire         wrControl  = wrEn & hitControl;
  wire         budgetWrOk = wrEn & hitBudget & budgetUnlock_r;
  wire         reqFund    = wrControl & reqIn.wdata[`SRCTL_CTL_FUND_BIT];
  wire         reqHot     = wrControl & reqIn.wdata[`SRCTL_CTL_HOT_BIT];
  wire         hotAny     = hotRstIn | (linkDownIn & ~linkDownDis_r);
  wire         delayDone  = delay_r == 32'h00000001;

  // Readout of the selected word, zero beyond seven
  wire [31:0]  budgetRead = (budgetSel_r < 8'(WORDS)) ?
                            budgetWord_r[budgetSel_r[2:0]] : 32'h00000000;

  wire [31:0]  statusWord = {22'h000000, strap_r.resetHold, strap_r.refClkMode,
                             strap_r.smbSlow, strap_r.clkUp, strap_r.clkDown,
                             2'h0, strap_r.mode};
  wire [31:0]  controlWord = {26'h0000000, linkDownDis_r, budgetUnlock_r, lockUnlock_r,
                              resetHold_r, 2'h0};

  wire [31:0]  readMux = hitBudget  ? budgetWord_r[budgetIdx] :
                         hitSel     ? {24'h000000, budgetSel_r} :
                         hitRead    ? budgetRead :
                         hitStatus  ? statusWord :
                         hitControl ? controlWord : 32'h00000000;

  // --------------------------------------------------------------------------
  // Delayed reset sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    delay_nxt = delay_r;
    case (state_r)
      SRCTL_IDLE: begin
        if (reqFund) begin
          state_nxt = SRCTL_WAIT_FUND;
          delay_nxt = DELAY_CYCLES;
        end else if (reqHot) begin
          state_nxt = SRCTL_WAIT_HOT;
          delay_nxt = DELAY_CYCLES;
        end
      end
      SRCTL_WAIT_FUND, SRCTL_WAIT_HOT: begin
        if (reqFund && state_r == SRCTL_WAIT_HOT) begin
          state_nxt = SRCTL_WAIT_FUND;
        end
        if (delayDone) begin
          state_nxt = SRCTL_IDLE;
          delay_nxt = 32'h00000000;
        end else begin
          delay_nxt = delay_r - 32'h00000001;
        end
      end
      default: begin
        state_nxt = SRCTL_IDLE;
        delay_nxt = 32'h00000000;
      end
    endcase
  end

  wire fireFund = delayDone & (state_r == SRCTL_WAIT_FUND);
  wire fireHot  = delayDone & (state_r == SRCTL_WAIT_HOT);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || fundRstIn) begin
      state_r <= SRCTL_IDLE;
      delay_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      delay_r <= delay_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Registers; sticky fields clear only on fundamental reset, budget words and select only on sys_rst
  // --------------------------------------------------------------------------
  wire fundAny = sys_rst | fundRstIn;

  always_ff @(posedge clk_sys) begin
    if (fundAny) begin
      strap_r        <= strapIn;
      resetHold_r    <= strapIn.resetHold;
      lockUnlock_r   <= 1'b1;
      budgetUnlock_r <= 1'b0;
      linkDownDis_r  <= 1'b0;
      inReset_r      <= 1'b1;
    end else if (hotAny || fireHot) begin
      resetHold_r    <= resetHold_r | strapIn.resetHold;
      lockUnlock_r   <= 1'b1;
      inReset_r      <= 1'b1;
    end else begin
      if (eepromInitIn) begin
        inReset_r <= 1'b0;
      end
      if (wrControl) begin
        if (inReset_r) begin
          resetHold_r <= reqIn.wdata[`SRCTL_CTL_HOLD_BIT];
        end
        lockUnlock_r  <= reqIn.wdata[`SRCTL_CTL_UNLOCK_BIT];
        linkDownDis_r <= reqIn.wdata[`SRCTL_CTL_LDDIS_BIT];
        if (lockUnlock_r) begin
          budgetUnlock_r <= reqIn.wdata[`SRCTL_CTL_BUDGET_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      budgetSel_r <= `SRCTL_SEL_RST;
      for (int i = 0; i < WORDS; i++) begin
        budgetWord_r[i] <= `SRCTL_BUDGET_WORD_RST;
      end
    end else begin
      if (budgetWrOk) begin
        budgetWord_r[budgetIdx] <= reqIn.wdata;
      end
      if (wrEn && hitSel) begin
        budgetSel_r <= reqIn.wdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rspOut             <= '0;
      fundRstOut         <= 1'b0;
      hotRstOut          <= 1'b0;
      linkRetrainOut     <= 1'b0;
      coreHoldOut        <= 1'b0;
      lockableWriteEnOut <= 1'b0;
    end else begin
      rspOut.valid       <= reqIn.valid;
      rspOut.rdata       <= rdEn ? readMux : 32'h00000000;
      fundRstOut         <= fireFund;
      hotRstOut          <= fireHot | hotAny;
      linkRetrainOut     <= fireHot;
      coreHoldOut        <= resetHold_r;
      lockableWriteEnOut <= lockUnlock_r;
    end
  end

endmodule : srctl_top

/* File: test/srctl_top_assertions.sv */
/* Port checker for srctl_top.
   Assumes a bind from the bench top that hands on DELAY_CYCLES. */
`timescale 1ns/1ps
module srctl_top_assertions #(
  parameter int unsigned DELAY_CYCLES = 4
) (
  input wire logic                   clk_sys,
  input wire logic                   sys_rst,
  input wire logic                   hotRstIn,
  input wire srctl_pkg::srctl_req_t  reqIn,
  input wire srctl_pkg::srctl_rsp_t  rspOut,
  input wire logic                   fundRstOut,
  input wire logic                   hotRstOut,
  input wire logic                   linkRetrainOut,
  input wire logic                   lockableWriteEnOut
);
  import srctl_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  localparam int DLO = DELAY_CYCLES - 1;
  localparam int DHI = DELAY_CYCLES;
  wire logic ctlWr = reqIn.valid && reqIn.write && reqIn.addr == 12'h404;
  wire logic ctlRd = reqIn.valid && !reqIn.write && reqIn.addr == 12'h404;
  // Completion leaves before any self reset
  sequence s_cmplFirst;
    rspOut.valid && !fundRstOut && !hotRstOut;
  endsequence
  property p_rsp; reqIn.valid |=> rspOut.valid; endproperty
  a_rsp: assert property (p_rsp) else $error("answer missing");
  property p_noRsp; !reqIn.valid |=> !rspOut.valid; endproperty
  a_noRsp: assert property (p_noRsp) else $error("answer unasked");
  property p_ctlRead; ctlRd |=> rspOut.rdata[1:0] == 2'b00; endproperty
  a_ctlRead: assert property (p_ctlRead) else $error("request bits read");
  property p_fundLater;
    ctlWr && reqIn.wdata[0] |=> s_cmplFirst ##[DLO:DHI] fundRstOut;
  endproperty
  a_fundLater: assert property (p_fundLater) else $error("fund delay");
  property p_hotLater;
    ctlWr && reqIn.wdata[1] && !reqIn.wdata[0]
      |=> s_cmplFirst ##[DLO:DHI] (hotRstOut && linkRetrainOut);
  endproperty
  a_hotLater: assert property (p_hotLater) else $error("hot delay");
  property p_extHot; hotRstIn |=> hotRstOut; endproperty
  a_extHot: assert property (p_extHot) else $error("hot input lost");
  property p_retrain; $rose(linkRetrainOut) |-> hotRstOut ##1 !linkRetrainOut; endproperty
  a_retrain: assert property (p_retrain) else $error("retrain alone");
  property p_unlock; $fell(sys_rst) |=> lockableWriteEnOut; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not set");
endmodule : srctl_top_assertions

/* File: test/srctl_host_model.sv */
/* Configuration requester model for srctl_top.
   Assumes the answer comes one cycle after the request. */
`timescale 1ns/1ps
module srctl_host_model (
  input  wire logic                  clk_sys,
  input  wire srctl_pkg::srctl_rsp_t rspOut,
  output srctl_pkg::srctl_req_t      reqIn
);
  import srctl_pkg::*;
  logic rspSeen;
  initial reqIn = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(negedge clk_sys);
    reqIn <= '{1'b1, w, a, d};
    @(negedge clk_sys);
    // Released fields are inverted so stale values never look valid
    reqIn <= '{1'b0, ~w, ~a, ~d};
    rspSeen = rspOut.valid;
    q = rspOut.rdata;
  endtask : xfer
endmodule : srctl_host_model

/* File: test/switch_reset_control_regs_tb.sv */
/* Self-checking bench for srctl_top with a short reset delay.
   Assumes requests come from srctl_host_model at the falling edge. */
`timescale 1ns/1ps
module switch_reset_control_regs_tb;
  import srctl_pkg::*;
  localparam int DLY = 4;
  logic         clk_sys = 1'b0;
  logic         sys_rst = 1'b1;
  logic         fundRstIn = 1'b0;
  logic         hotRstIn = 1'b0;
  logic         linkDownIn = 1'b0;
  logic         eepromInitIn = 1'b0;
  srctl_strap_t strapIn = '{3'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  srctl_req_t   reqIn;
  srctl_rsp_t   rspOut;
  logic         fundRstOut, hotRstOut, linkRetrainOut, coreHoldOut, lockableWriteEnOut;
  wire logic [1:0] pulse = {hotRstOut, fundRstOut};
  int           errors = 0;
  int           samples_checked = 0;
  int           n;
  logic [31:0]  q;
  always #10 clk_sys = ~clk_sys;
  srctl_top #(.DELAY_CYCLES(DLY)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .fundRstIn(fundRstIn), .hotRstIn(hotRstIn), .linkDownIn(linkDownIn),
    .eepromInitIn(eepromInitIn), .strapIn(strapIn), .reqIn(reqIn), .rspOut(rspOut),
    .fundRstOut(fundRstOut), .hotRstOut(hotRstOut), .linkRetrainOut(linkRetrainOut),
    .coreHoldOut(coreHoldOut), .lockableWriteEnOut(lockableWriteEnOut));
  srctl_host_model u_host (.clk_sys(clk_sys), .rspOut(rspOut), .reqIn(reqIn));
  task automatic test_done();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
    chk("writeDone", {31'h0, u_host.rspSeen}, 32'h1);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rd
  task automatic waitPulse(input int b);
    for (n = 0; n < 20 && pulse[b] !== 1'b1; n++) @(negedge clk_sys);
    if (n == 20) begin
      errors++;
      test_done();
    end
  endtask : waitPulse
  task automatic sc_status();
    strapIn = '0;
    rd(12'h400, 32'h000000a1, "status");
    wr(12'h400, 32'hffffffff);
    rd(12'h400, 32'h000000a1, "statusRo");
    rd(12'h500, 32'h0, "unmapped");
    rd(12'h404, 32'h00000008, "ctlReset");
  endtask : sc_status
  task automatic sc_hold();
    wr(12'h404, 32'h0000000c);
    @(negedge clk_sys);
    chk("holdSet", coreHoldOut, 1);
    wr(12'h404, 32'h00000008);
    @(negedge clk_sys);
    chk("holdClr", coreHoldOut, 0);
    @(negedge clk_sys) eepromInitIn = 1'b1;
    @(negedge clk_sys) eepromInitIn = 1'b0;
    wr(12'h404, 32'h0000000c);
    @(negedge clk_sys);
    chk("holdLate", coreHoldOut, 0);
  endtask : sc_hold
  task automatic sc_budget();
    wr(12'h404, 32'h00000018);
    for (int i = 0; i < 8; i++) wr(12'h300 + 12'(4 * i), 32'hb0d00000 | i);
    for (int i = 0; i < 9; i++) begin
      wr(12'h284, i);
      rd(12'h288, (i < 8) ? 32'hb0d00000 | i : 32'h0, "readout");
    end
    rd(12'h31c, 32'hb0d00007, "lastWord");
    wr(12'h404, 32'h00000008);
    wr(12'h300, 32'h00001234);
    wr(12'h31c, 32'h00001234);
    rd(12'h300, 32'hb0d00000, "lockedWord");
    rd(12'h31c, 32'hb0d00007, "lockedLast");
    wr(12'h404, 32'h0);
    wr(12'h404, 32'h00000010);
    rd(12'h404, 32'h0, "lockedCtl");
  endtask : sc_budget
  task automatic sc_hot();
    @(negedge clk_sys) hotRstIn = 1'b1;
    @(negedge clk_sys) chk("extHot", hotRstOut, 1);
    hotRstIn = 1'b0;
    wr(12'h404, 32'h00000020);
    linkDownIn = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("linkMasked", hotRstOut, 0);
    linkDownIn = 1'b0;
    wr(12'h404, 32'h0);
    linkDownIn = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("linkHot", hotRstOut, 1);
    linkDownIn = 1'b0;
    wr(12'h404, 32'h00000002);
    waitPulse(1);
    chk("hotDelay", 32'(n >= DLY - 1 && n <= DLY), 1);
    chk("retrain", linkRetrainOut, 1);
    repeat (2) @(negedge clk_sys);
    chk("unlockHot", lockableWriteEnOut, 1);
    rd(12'h404, 32'h00000008, "ctlHot");
    rd(12'h300, 32'hb0d00000, "stickyWord");
  endtask : sc_hot
  task automatic sc_fund();
    wr(12'h404, 32'h00000001);
    waitPulse(0);
    chk("fundDelay", 32'(n >= DLY - 1 && n <= DLY), 1);
  endtask : sc_fund
  task automatic sc_fundPin();
    @(negedge clk_sys);
    strapIn   = '{3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    fundRstIn = 1'b1;
    repeat (2) @(negedge clk_sys);
    fundRstIn = 1'b0;
    strapIn   = '0;
    rd(12'h400, 32'h00000340, "strapRelatch");
    rd(12'h404, 32'h0000000c, "ctlFund");
    chk("holdStrap", coreHoldOut, 1);
    chk("unlockFund", lockableWriteEnOut, 1);
    wr(12'h404, 32'h00000008);
    @(negedge clk_sys);
    chk("holdRelease", coreHoldOut, 0);
  endtask : sc_fundPin
  initial begin
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    sc_status();
    sc_hold();
    sc_budget();
    sc_hot();
    sc_fund();
    sc_fundPin();
    test_done();
  end
endmodule : switch_reset_control_regs_tb
bind srctl_top srctl_top_assertions #(.DELAY_CYCLES(DELAY_CYCLES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .hotRstIn(hotRstIn), .reqIn(reqIn),
  .rspOut(rspOut), .fundRstOut(fundRstOut), .hotRstOut(hotRstOut),
  .linkRetrainOut(linkRetrainOut), .lockableWriteEnOut(lockableWriteEnOut));
